// File: src/mcs_defines.svh
// Register offsets, field positions, reset values and timing counts for the clock select block.
// Assumes a 32-bit register port with byte addresses; included by bare name.
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH
// Register byte offsets
`define MCS_OFF_MAIN_CLOCK_CONTROL 10'h000
`define MCS_OFF_CPU_CLOCK_SELECT 10'h004
`define MCS_OFF_BUS_CLOCK_SELECT 10'h008
`define MCS_OFF_PERIPH_A_CLOCK_SELECT 10'h00C
`define MCS_OFF_PERIPH_B_CLOCK_SELECT 10'h010
`define MCS_OFF_CPU_CLOCK_GATE 10'h020
`define MCS_OFF_BUS_CLOCK_GATE 10'h024
`define MCS_OFF_PERIPH_A_CLOCK_GATE 10'h028
`define MCS_OFF_PERIPH_B_CLOCK_GATE 10'h02C
`define MCS_OFF_DIVIDED_CLOCK_GATE 10'h040
`define MCS_OFF_FAILURE_DETECTOR_CONTROL 10'h054
`define MCS_OFF_WRITE_UNLOCK 10'h058
`define MCS_OFF_IRQ_ENABLE 10'h0C0
`define MCS_OFF_IRQ_DISABLE 10'h0C4
`define MCS_OFF_IRQ_MASK 10'h0C8
`define MCS_OFF_IRQ_STATUS 10'h0CC
`define MCS_OFF_IRQ_CLEAR 10'h0D0
`define MCS_OFF_MANAGER_STATUS 10'h0D4
`define MCS_OFF_PERIPH_POWER_CONTROL 10'h160
`define MCS_OFF_RESET_CAUSE 10'h180
`define MCS_OFF_WAKE_CAUSE 10'h184
`define MCS_OFF_ASYNC_WAKE_ENABLE 10'h188
`define MCS_OFF_CONFIGURATION_INFO 10'h3F8
`define MCS_OFF_VERSION_INFO 10'h3FC
// Reset values
`define MCS_RST_ZERO 32'h00000000
`define MCS_RST_CPU_CLOCK_GATE 32'h00010001
`define MCS_RST_BUS_CLOCK_GATE 32'h0000007F
`define MCS_RST_PERIPH_A_CLOCK_GATE 32'h00FFFFFF
`define MCS_RST_PERIPH_B_CLOCK_GATE 32'h0000000F
`define MCS_RST_DIVIDED_CLOCK_GATE 32'h0000007F
`define MCS_RST_PERIPH_POWER_CONTROL 32'h000001FA
`define MCS_RST_CONFIGURATION_INFO 32'h00000043
// Arbitrary version value, not tied to any part
`define MCS_VERSION_VALUE 32'h00000100
// Field positions and widths
`define MCS_SEL_W 3
`define MCS_DIV_BIT 7
`define MCS_SEL_MASK 32'h00000087
`define MCS_MAIN_SEL_MASK 32'h00000007
`define MCS_FDC_MASK 32'h80000001
// Status and interrupt bit positions
`define MCS_ST_CFD 0
`define MCS_ST_READY 5
`define MCS_ST_W 6
`define MCS_ST_RESET_VAL 6'h20
// Cycles from a select write until the new ratio is in force
`define MCS_SETTLE_CYCLES 4'h8
`endif

// File: src/mcs_pkg.sv
// Types shared by the clock select block.
// Assumes the defines header provides all numeric constants.
package mcs_pkg;
    // Main clock sources by select code
    typedef enum logic [2:0] {
        MCS_SRC_SYSTEM_RC_OSC = 3'h0,
        MCS_SRC_CRYSTAL_OSC_ZERO = 3'h1,
        MCS_SRC_FREQ_LOCKED_LOOP = 3'h2,
        MCS_SRC_FAST_RC_OSC = 3'h3
    } mcs_source_t;
    // Ratio update sequencer, one-hot
    typedef enum logic [1:0] {
        MCS_ST_IDLE = 2'b01,
        MCS_ST_SETTLE = 2'b10
    } mcs_state_t;
endpackage : mcs_pkg

// File: src/mcs_clock_select.sv
// Main clock source select and CPU clock prescaler of the power manager.
// Assumes a single 250 MHz clock, synchronous active-high reset and a plain
// register port with read data one cycle after the read strobe.
// Software must keep to the ready handshake; select writes are not locked.
//
// Design decision made here: the plain strobed port.
`include "mcs_defines.svh"
module mcs_clock_select (
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic main_clock_fail,
    input wire logic [31:0] reset_cause_in,
    input wire logic [31:0] wake_cause_in,
    output logic [2:0] main_source_sel,
    output logic cpu_divide_enable,
    output logic [2:0] cpu_prescale_exp,
    output logic [8:0] cpu_divide_ratio,
    output logic cpu_clock_tick,
    output logic irq
);
    // Failure and cause pins from other domains, two-stage synchronisers
    logic fail_meta;
    logic fail_sync;
    logic [31:0] reset_cause_meta;
    logic [31:0] reset_cause_sync;
    logic [31:0] wake_cause_meta;
    logic [31:0] wake_cause_sync;
    logic fail_prev;
    logic fail_event;
    // Software-visible registers
    logic [31:0] main_clock_control;
    logic [31:0] cpu_clock_select;
    logic [31:0] periph_a_clock_select;
    logic [31:0] periph_b_clock_select;
    logic [31:0] cpu_clock_gate;
    logic [31:0] bus_clock_gate;
    logic [31:0] periph_a_clock_gate;
    logic [31:0] periph_b_clock_gate;
    logic [31:0] divided_clock_gate;
    logic [31:0] failure_detector_control;
    logic [31:0] periph_power_control;
    logic [31:0] async_wake_enable;
    logic [`MCS_ST_W-1:0] irq_mask;
    logic [`MCS_ST_W-1:0] irq_status;
    logic [`MCS_ST_W-1:0] manager_status;
    logic [`MCS_ST_W-1:0] status_prev;
    // Ratio sequencer
    mcs_pkg::mcs_state_t state;
    logic [3:0] settle_cnt;
    logic [2:0] active_exp;
    logic active_div;
    logic [7:0] div_cnt;
    // Write decode
    logic wr_main;
    logic wr_cpu;
    logic wr_pba;
    logic wr_pbb;
    logic sel_write;

    // Address match for a write strobe
    function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
        // Full ten-bit compare, no aliasing
        hit = (a == off);
    endfunction : hit

    // Division ratio of a select value
    function automatic logic [8:0] ratio(input logic dv, input logic [2:0] ex);
        // Two to the power of exponent plus one
        ratio = dv ? (9'h002 << ex) : 9'h001;
    endfunction : ratio

    assign wr_main = reg_write && hit(reg_addr, `MCS_OFF_MAIN_CLOCK_CONTROL);
    assign wr_cpu = reg_write && hit(reg_addr, `MCS_OFF_CPU_CLOCK_SELECT);
    assign wr_pba = reg_write && hit(reg_addr, `MCS_OFF_PERIPH_A_CLOCK_SELECT);
    assign wr_pbb = reg_write && hit(reg_addr, `MCS_OFF_PERIPH_B_CLOCK_SELECT);
    assign sel_write = wr_cpu || wr_pba || wr_pbb;

    // Synchronise foreign inputs
    always_ff @(posedge clock) begin
        if (rst) begin
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
            fail_prev <= 1'b0;
            reset_cause_meta <= `MCS_RST_ZERO;
            reset_cause_sync <= `MCS_RST_ZERO;
            wake_cause_meta <= `MCS_RST_ZERO;
            wake_cause_sync <= `MCS_RST_ZERO;
        end else begin
            // Two stages before any logic reads a pin
            fail_meta <= main_clock_fail;
            fail_sync <= fail_meta;
            fail_prev <= fail_sync;
            // Cause words are quasi-static levels
            reset_cause_meta <= reset_cause_in;
            reset_cause_sync <= reset_cause_meta;
            wake_cause_meta <= wake_cause_in;
            wake_cause_sync <= wake_cause_meta;
        end
    end

    // Failure counts only while detector enabled and source is not RC
    // Only the rising edge of a failure counts, once
    assign fail_event = fail_sync && !fail_prev && failure_detector_control[0]
        && (main_clock_control[2:0] != mcs_pkg::MCS_SRC_SYSTEM_RC_OSC);

    // Main clock control; failure forces RC and wins over a write
    always_ff @(posedge clock) begin
        if (rst) begin
            // RC source after reset
            main_clock_control <= `MCS_RST_ZERO;
        end else if (fail_event) begin
            // Detected failure falls back to RC
            main_clock_control <= `MCS_RST_ZERO;
        end else if (wr_main) begin
            // Keep only the source code field
            main_clock_control <= reg_wdata & `MCS_MAIN_SEL_MASK;
        end
    end

    // Clock select registers
    always_ff @(posedge clock) begin
        if (rst) begin
            cpu_clock_select <= `MCS_RST_ZERO;
            periph_a_clock_select <= `MCS_RST_ZERO;
            periph_b_clock_select <= `MCS_RST_ZERO;
        end else begin
            // CPU ratio request, applied after settling
            if (wr_cpu) begin
                cpu_clock_select <= reg_wdata & `MCS_SEL_MASK;
            end
            // Peripheral selects are stored and restart settling, but drive no output
            if (wr_pba) begin
                periph_a_clock_select <= reg_wdata & `MCS_SEL_MASK;
            end
            if (wr_pbb) begin
                periph_b_clock_select <= reg_wdata & `MCS_SEL_MASK;
            end
        end
    end

    // Plain storage registers
    always_ff @(posedge clock) begin
        if (rst) begin
            // Gate masks come up with their default enables
            cpu_clock_gate <= `MCS_RST_CPU_CLOCK_GATE;
            bus_clock_gate <= `MCS_RST_BUS_CLOCK_GATE;
            periph_a_clock_gate <= `MCS_RST_PERIPH_A_CLOCK_GATE;
            periph_b_clock_gate <= `MCS_RST_PERIPH_B_CLOCK_GATE;
            divided_clock_gate <= `MCS_RST_DIVIDED_CLOCK_GATE;
            failure_detector_control <= `MCS_RST_ZERO;
            periph_power_control <= `MCS_RST_PERIPH_POWER_CONTROL;
            async_wake_enable <= `MCS_RST_ZERO;
        end else if (reg_write) begin
            // One decode per write strobe
            unique case (reg_addr)
                `MCS_OFF_CPU_CLOCK_GATE: cpu_clock_gate <= reg_wdata;
                `MCS_OFF_BUS_CLOCK_GATE: bus_clock_gate <= reg_wdata;
                `MCS_OFF_PERIPH_A_CLOCK_GATE: periph_a_clock_gate <= reg_wdata;
                `MCS_OFF_PERIPH_B_CLOCK_GATE: periph_b_clock_gate <= reg_wdata;
                `MCS_OFF_DIVIDED_CLOCK_GATE: divided_clock_gate <= reg_wdata;
                `MCS_OFF_FAILURE_DETECTOR_CONTROL: failure_detector_control <= reg_wdata & `MCS_FDC_MASK;
                `MCS_OFF_PERIPH_POWER_CONTROL: periph_power_control <= reg_wdata;
                `MCS_OFF_ASYNC_WAKE_ENABLE: async_wake_enable <= reg_wdata;
                // Reserved and read-only offsets drop writes
                default: ;
            endcase
        end
    end

    // Sequencer: a select write restarts settling, then new ratio applies
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= mcs_pkg::MCS_ST_IDLE;
            settle_cnt <= 4'h0;
            active_div <= 1'b0;
            active_exp <= 3'h0;
        end else if (sel_write) begin
            // Any select write restarts the settle count
            state <= mcs_pkg::MCS_ST_SETTLE;
            settle_cnt <= `MCS_SETTLE_CYCLES;
        end else begin
            unique case (state)
                mcs_pkg::MCS_ST_IDLE: begin
                    // Nothing pending
                    settle_cnt <= 4'h0;
                end
                mcs_pkg::MCS_ST_SETTLE: begin
                    if (settle_cnt == 4'h1) begin
                        // New CPU ratio takes effect here
                        active_div <= cpu_clock_select[`MCS_DIV_BIT];
                        active_exp <= cpu_clock_select[2:0];
                        state <= mcs_pkg::MCS_ST_IDLE;
                    end
                    // Count down towards the switch-over
                    settle_cnt <= settle_cnt - 4'h1;
                end
            endcase
        end
    end

    // Manager status: ready and failure level
    always_ff @(posedge clock) begin
        if (rst) begin
            manager_status <= `MCS_ST_RESET_VAL;
        end else begin
            // Ready clears on a select write, sets when settled
            if (sel_write) begin
                manager_status[`MCS_ST_READY] <= 1'b0;
            end else if (state == mcs_pkg::MCS_ST_SETTLE && settle_cnt == 4'h1) begin
                manager_status[`MCS_ST_READY] <= 1'b1;
            end
            // Failure level, cleared by any main control write while the source is RC
            if (fail_event) begin
                manager_status[`MCS_ST_CFD] <= 1'b1;
            end else if (main_clock_control[2:0] == mcs_pkg::MCS_SRC_SYSTEM_RC_OSC && wr_main) begin
                manager_status[`MCS_ST_CFD] <= 1'b0;
            end
        end
    end

    // Interrupt status: set on rising status bit, set wins over clear
    always_ff @(posedge clock) begin
        if (rst) begin
            status_prev <= `MCS_ST_RESET_VAL;
            irq_status <= '0;
        end else begin
            // Edge detect against last cycle's status
            status_prev <= manager_status;
            irq_status <= (irq_status & ~((reg_write && hit(reg_addr, `MCS_OFF_IRQ_CLEAR))
                ? reg_wdata[`MCS_ST_W-1:0] : '0))
                | (manager_status & ~status_prev);
        end
    end

    // Interrupt mask: enable sets, disable clears
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_mask <= '0;
        end else if (reg_write && hit(reg_addr, `MCS_OFF_IRQ_ENABLE)) begin
            // Enable writes add mask bits
            irq_mask <= irq_mask | reg_wdata[`MCS_ST_W-1:0];
        end else if (reg_write && hit(reg_addr, `MCS_OFF_IRQ_DISABLE)) begin
            // Disable writes remove mask bits
            irq_mask <= irq_mask & ~reg_wdata[`MCS_ST_W-1:0];
        end
    end

    // Read data, one cycle after the strobe, zero elsewhere
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= `MCS_RST_ZERO;
        end else if (reg_read) begin
            // Decode the read address
            unique case (reg_addr)
                `MCS_OFF_MAIN_CLOCK_CONTROL: reg_rdata <= main_clock_control;
                `MCS_OFF_CPU_CLOCK_SELECT: reg_rdata <= cpu_clock_select;
                `MCS_OFF_BUS_CLOCK_SELECT: reg_rdata <= cpu_clock_select;
                `MCS_OFF_PERIPH_A_CLOCK_SELECT: reg_rdata <= periph_a_clock_select;
                `MCS_OFF_PERIPH_B_CLOCK_SELECT: reg_rdata <= periph_b_clock_select;
                `MCS_OFF_CPU_CLOCK_GATE: reg_rdata <= cpu_clock_gate;
                `MCS_OFF_BUS_CLOCK_GATE: reg_rdata <= bus_clock_gate;
                `MCS_OFF_PERIPH_A_CLOCK_GATE: reg_rdata <= periph_a_clock_gate;
                `MCS_OFF_PERIPH_B_CLOCK_GATE: reg_rdata <= periph_b_clock_gate;
                `MCS_OFF_DIVIDED_CLOCK_GATE: reg_rdata <= divided_clock_gate;
                `MCS_OFF_FAILURE_DETECTOR_CONTROL: reg_rdata <= failure_detector_control;
                `MCS_OFF_IRQ_MASK: reg_rdata <= {26'h0, irq_mask};
                `MCS_OFF_IRQ_STATUS: reg_rdata <= {26'h0, irq_status};
                `MCS_OFF_MANAGER_STATUS: reg_rdata <= {26'h0, manager_status};
                `MCS_OFF_PERIPH_POWER_CONTROL: reg_rdata <= periph_power_control;
                `MCS_OFF_RESET_CAUSE: reg_rdata <= reset_cause_sync;
                `MCS_OFF_WAKE_CAUSE: reg_rdata <= wake_cause_sync;
                `MCS_OFF_ASYNC_WAKE_ENABLE: reg_rdata <= async_wake_enable;
                `MCS_OFF_CONFIGURATION_INFO: reg_rdata <= `MCS_RST_CONFIGURATION_INFO;
                `MCS_OFF_VERSION_INFO: reg_rdata <= `MCS_VERSION_VALUE;
                // Write-only and reserved read zero
                default: reg_rdata <= `MCS_RST_ZERO;
            endcase
        end else begin
            // Bus idles at zero between reads
            reg_rdata <= `MCS_RST_ZERO;
        end
    end

    // CPU clock tick generator from applied ratio
    always_ff @(posedge clock) begin
        if (rst) begin
            div_cnt <= 8'h00;
            cpu_clock_tick <= 1'b0;
        end else if (!active_div) begin
            // Undivided: tick every cycle
            div_cnt <= 8'h00;
            cpu_clock_tick <= 1'b1;
        end else if (div_cnt >= ratio(1'b1, active_exp) - 9'h001) begin
            // Last cycle of the period
            div_cnt <= 8'h00;
            cpu_clock_tick <= 1'b1;
        end else begin
            // Still inside the period
            div_cnt <= div_cnt + 8'h01;
            cpu_clock_tick <= 1'b0;
        end
    end

    // Registered clock control outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            main_source_sel <= 3'h0;
            cpu_divide_enable <= 1'b0;
            cpu_prescale_exp <= 3'h0;
            cpu_divide_ratio <= 9'h001;
            irq <= 1'b0;
        end else begin
            main_source_sel <= main_clock_control[2:0];
            // Only settled ratio values reach the pins
            cpu_divide_enable <= active_div;
            cpu_prescale_exp <= active_exp;
            cpu_divide_ratio <= ratio(active_div, active_exp);
            // Level request while any unmasked bit is set
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule : mcs_clock_select

// File: sim/mcs_clock_select_assertions.sv
// Port-level assertions for the clock select block.
// Assumes it is bound onto mcs_clock_select; bind at the foot.
module mcs_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic main_clock_fail,
    input wire logic [2:0] main_source_sel,
    input wire logic cpu_divide_enable,
    input wire logic [2:0] cpu_prescale_exp,
    input wire logic [8:0] cpu_divide_ratio,
    input wire logic cpu_clock_tick,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic fdc_en; // Failure detector on
    logic [3:0] quiet; // Cycles since a select write
    logic sel_wr; // Any select write
    assign sel_wr = reg_write && (reg_addr == 10'h004 || reg_addr == 10'h00C || reg_addr == 10'h010);
    // Follows the detector enable bit
    always_ff @(posedge clock) begin
        if (rst) begin
            fdc_en <= 1'b0;
        end else if (reg_write && reg_addr == 10'h054) begin
            fdc_en <= reg_wdata[0];
        end
    end
    // Saturating quiet count, so settled outputs can be judged
    always_ff @(posedge clock) begin
        if (rst || sel_wr) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    a_reset_state: assert property (
        $fell(rst) |-> main_source_sel == 3'h0 && !cpu_divide_enable && cpu_divide_ratio == 9'h1)
        else $error("Outputs not at reset state");
    a_ratio_value: assert property (
        quiet == 4'hF |-> cpu_divide_ratio == (cpu_divide_enable ? 9'h1 << (cpu_prescale_exp + 4'h1) : 9'h1))
        else $error("Divide ratio wrong");
    a_tick_full: assert property (
        quiet == 4'hF && !cpu_divide_enable |-> cpu_clock_tick)
        else $error("Undivided tick missing");
    a_tick_gap: assert property (
        quiet == 4'hF && cpu_clock_tick && cpu_divide_ratio == 9'h4 |=> !cpu_clock_tick [*3] ##1 cpu_clock_tick)
        else $error("Tick spacing wrong");
    a_settle_hold: assert property (
        sel_wr |=> ($stable(cpu_divide_enable) && $stable(cpu_prescale_exp)) [*6])
        else $error("Ratio changed before settling");
    a_sel_applied: assert property (
        reg_write && reg_addr == 10'h004 |-> ##10
        {24'h0, cpu_divide_enable, 4'h0, cpu_prescale_exp} == ($past(reg_wdata, 10) & 32'h00000087))
        else $error("Written select not applied");
    a_ready_drop: assert property (
        (reg_write && reg_addr == 10'h004) ##2 (reg_read && reg_addr == 10'h0D4) |=> !reg_rdata[5])
        else $error("Ready still high after select write");
    a_irq_off: assert property (
        reg_write && reg_addr == 10'h0C4 && reg_wdata == 32'hFFFFFFFF |=> ##1 !irq)
        else $error("Interrupt high with all masked");
    a_fail_rc: assert property (
        $rose(main_clock_fail) && fdc_en && main_source_sel != 3'h0 |-> ##[1:6] main_source_sel == 3'h0)
        else $error("Failure did not force RC source");
endmodule : mcs_checker

bind mcs_clock_select mcs_checker u_mcs_checker (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .main_clock_fail(main_clock_fail),
    .main_source_sel(main_source_sel), .cpu_divide_enable(cpu_divide_enable),
    .cpu_prescale_exp(cpu_prescale_exp), .cpu_divide_ratio(cpu_divide_ratio),
    .cpu_clock_tick(cpu_clock_tick), .irq(irq));

// File: sim/tb_top.sv
// Self-checking bench for the clock select block.
// Assumes the design, its defines header and the bound checker.
`include "mcs_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0; // 250 MHz clock
    logic rst = 1'b1; // Synchronous reset
    logic [9:0] reg_addr = 10'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic main_clock_fail = 1'b0; // Failure indication
    logic [31:0] reg_rdata;
    logic [2:0] main_source_sel;
    logic cpu_divide_enable;
    logic [2:0] cpu_prescale_exp;
    logic [8:0] cpu_divide_ratio;
    logic cpu_clock_tick;
    logic irq;
    int miscompares = 0; // Mismatches
    int num_checks = 0; // Comparisons
    logic [31:0] rv; // Last read data
    mcs_clock_select u_mcs_clock_select (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .main_clock_fail(main_clock_fail),
        .reset_cause_in(32'h00000011), .wake_cause_in(32'h00000004),
        .main_source_sel(main_source_sel), .cpu_divide_enable(cpu_divide_enable),
        .cpu_prescale_exp(cpu_prescale_exp), .cpu_divide_ratio(cpu_divide_ratio),
        .cpu_clock_tick(cpu_clock_tick), .irq(irq));
    // Clock, 2 ns half period
    always #2 clock = ~clock;
    // Ends the run with the verdict
    task automatic test_done();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    // Compares one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Write strobe, then one idle cycle
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr
    // Read strobe; data taken in the following cycle, while it stands
    task automatic rd(input logic [9:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
        @(posedge clock);
    endtask : rd
    // Read and compare against the expected word
    task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
        rd(a);
        chk(rv, e);
    endtask : rdchk
    // Polls status until ready, bounded; the polls judge nothing
    task automatic wait_ready();
        for (int i = 0; i < 20 && rv[5] !== 1'b1; i++) begin
            rd(10'h0D4);
        end
        chk(rv, 32'h00000020);
    endtask : wait_ready
    // Reset values across the map, reserved and write-only too
    task automatic t_reset();
        logic [9:0] a [22] = '{10'h000, 10'h004, 10'h008, 10'h00C, 10'h010, 10'h014, 10'h020, 10'h024,
            10'h028, 10'h02C, 10'h040, 10'h054, 10'h058, 10'h0C8, 10'h0CC, 10'h0D4, 10'h160, 10'h180,
            10'h184, 10'h188, 10'h3F8, 10'h3FC};
        logic [31:0] v [22] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00010001, 32'h7F,
            32'h00FFFFFF, 32'hF, 32'h7F, 32'h0, 32'h0, 32'h0, 32'h0, 32'h20, 32'h1FA, 32'h11,
            32'h4, 32'h0, 32'h43, `MCS_VERSION_VALUE};
        foreach (a[k]) begin
            rdchk(a[k], v[k]);
        end
        chk({29'h0, main_source_sel}, 32'h0);
        chk({23'h0, cpu_divide_ratio}, 32'h1);
    endtask : t_reset
    // Read-write and read-only places
    task automatic t_regs();
        wr(10'h160, 32'h0);
        rdchk(10'h160, 32'h0);
        wr(10'h054, 32'h1);
        rdchk(10'h054, 32'h1);
        wr(10'h3FC, 32'hFFFFFFFF);
        rdchk(10'h3FC, `MCS_VERSION_VALUE);
        wr(10'h008, 32'hFFFFFFFF);
        rdchk(10'h008, 32'h0);
        wr(10'h014, 32'hFFFFFFFF);
        rdchk(10'h014, 32'h0);
    endtask : t_regs
    // CPU ratios, ready handshake and tick counts
    task automatic t_cpu();
        logic [7:0] s [4] = '{8'h87, 8'h80, 8'h00, 8'h81};
        int r;
        int n;
        foreach (s[k]) begin
            wr(10'h004, {24'h0, s[k]});
            rdchk(10'h0D4, 32'h0);
            wait_ready();
            r = s[k][7] ? (1 << (s[k][2:0] + 1)) : 1;
            chk({23'h0, cpu_divide_ratio}, r);
            chk({24'h0, cpu_divide_enable, 4'h0, cpu_prescale_exp}, {24'h0, s[k]});
            rdchk(10'h008, {24'h0, s[k]});
            n = 0;
            repeat (512) begin
                @(posedge clock);
                #1 n += (cpu_clock_tick === 1'b1);
            end
            chk(n, 512 / r);
        end
        wr(10'h00C, 32'h0);
        rdchk(10'h0D4, 32'h0);
        wait_ready();
    endtask : t_cpu
    // Every main source code; divider already at four
    task automatic t_main();
        for (int v = 0; v < 4; v++) begin
            wr(10'h000, v);
            rdchk(10'h000, v);
            chk({29'h0, main_source_sel}, v);
        end
    endtask : t_main
    // Status, mask, disable and clear
    task automatic t_irq();
        rdchk(10'h0CC, 32'h20);
        chk({31'h0, irq}, 32'h0);
        wr(10'h0C0, 32'h20);
        rdchk(10'h0C8, 32'h20);
        chk({31'h0, irq}, 32'h1);
        wr(10'h0C4, 32'hFFFFFFFF);
        rdchk(10'h0C8, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(10'h0C0, 32'h20);
        wr(10'h0D0, 32'h20);
        rdchk(10'h0CC, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq
    // Clock failure on crystal, then a reset in mid-run
    task automatic t_fail();
        wr(10'h000, 32'h1);
        main_clock_fail <= 1'b1;
        repeat (8) @(posedge clock);
        main_clock_fail <= 1'b0;
        rdchk(10'h000, 32'h0);
        chk({29'h0, main_source_sel}, 32'h0);
        rdchk(10'h0CC, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({23'h0, cpu_divide_ratio}, 32'h1);
        rdchk(10'h004, 32'h0);
    endtask : t_fail
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_regs();
        t_cpu();
        t_main();
        t_irq();
        t_fail();
        test_done();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        test_done();
    end
endmodule : tb_top
